// *** rtl/burner_cmd_pkg.sv ***
// Constants for the remote command and terminal status register block.
// Assumes a 16-bit register port driven by a serial bus front end on the same clock.
//
// Function
// - Bit 0 returns to autonomous operation
// - Bit 1 keeps burner off
// - Bit 2 drives high fire in run
// - Bit 3 drives low fire in run
// - Bit 4 performs a remote reset
// - Bits 5-7 zero; bits 8-14 ignored
// - Bit 15 copied to control status
// - Lapsed refresh leaves the commanded state
// - Read-only 32-bit terminal status word
// - Fixed terminal bit assignments
// - Bit 0 least, bit 31 most significant
// - 32-bit pairs ordered by word order setting
package burner_cmd_pkg;

	// ----------------------------------------
	// Register offsets (16-bit word addresses)
	// ----------------------------------------
	localparam logic [15:0] TERM_WORD_A_OFS = 16'h006a;
	localparam logic [15:0] TERM_WORD_B_OFS = 16'h006b;
	localparam logic [15:0] CMD_WORD_OFS = 16'h01b9;
	localparam logic [15:0] CTL_STATUS_OFS = 16'h01ba;
	localparam logic [15:0] WORD_ORDER_OFS = 16'h01bc;

	// ----------------------------------------
	// Command word fields
	// ----------------------------------------
	localparam int CMD_AUTO_BIT = 0;
	localparam int CMD_OFF_BIT = 1;
	localparam int CMD_HIGH_BIT = 2;
	localparam int CMD_LOW_BIT = 3;
	localparam int CMD_RESET_BIT = 4;
	localparam int CMD_COPY_BIT = 15;
	localparam logic [7:0] CMD_MUST_ZERO_MASK = 8'he0;

	// ----------------------------------------
	// Terminal status bit positions
	// ----------------------------------------
	localparam int TERM_RUN_TEST_BIT = 0;
	localparam int TERM_FAN_BIT = 5;
	localparam int TERM_ALARM_BIT = 24;
	localparam int TERM_MODULATE_BIT = 25;
	localparam int TERM_RESET_BIT = 26;
	localparam int TERM_SAFETY_RELAY_BIT = 27;
	localparam int TERM_FLAME_INTERLOCK_BIT = 28;
	localparam int TERM_WIDTH = 32;

	// ----------------------------------------
	// Word order setting
	// ----------------------------------------
	localparam logic WORD_ORDER_MS_FIRST = 1'b0;
	localparam logic WORD_ORDER_LS_FIRST = 1'b1;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] CMD_WORD_RESET = 16'h0001;
	localparam logic WORD_ORDER_RESET = 1'b0;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam longint CLK_HZ = 64'd250_000_000;
	localparam longint REFRESH_LIMIT_S = 64'd120;
	localparam int REFRESH_W = 35;
	localparam logic [REFRESH_W-1:0] REFRESH_CYCLES = REFRESH_W'(REFRESH_LIMIT_S * CLK_HZ);

	// ----------------------------------------
	// Remote command modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		MODE_AUTO = 2'b00,
		MODE_OFF = 2'b01,
		MODE_HIGH = 2'b10,
		MODE_LOW = 2'b11
	} mode_t;

endpackage : burner_cmd_pkg

// *** rtl/bit_sync.sv ***
// Two-flop synchroniser for a bundle of independent level inputs.
// Assumes each bit is a slow level; bits are not coherent with each other.
`timescale 1ns/10ps
module bit_sync #(
	parameter int WIDTH = 32
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Data
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_t;

	sync_t sync_r;
	sync_t sync_nxt;

	// The first stage feeds only the second stage.
	always_comb begin
		sync_nxt.meta = i_async;
		sync_nxt.stable = sync_r.meta;
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sync_r <= '0;
		end else begin
			sync_r <= sync_nxt;
		end
	end

	assign o_sync = sync_r.stable;

endmodule : bit_sync

// *** rtl/burner_remote_command_regs.sv ***
// Remote command interpreter and terminal status words of a burner control.
// Assumes a 16-bit word register port on i_clk and terminal pins asynchronous to it.
`timescale 1ns/10ps
module burner_remote_command_regs #(
	parameter logic [burner_cmd_pkg::REFRESH_W-1:0] REFRESH_CYCLES = burner_cmd_pkg::REFRESH_CYCLES
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Register port
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [15:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	output logic [15:0] o_reg_rdata,
	output logic o_reg_rvalid,
	// Burner control side
	input wire logic [31:0] i_terminals,
	input wire logic i_run_phase,
	output logic o_fire_inhibit,
	output logic o_drive_high_fire,
	output logic o_drive_low_fire,
	output logic o_remote_reset,
	output logic o_remote_active
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [15:0] cmd_word;
		logic ctl_copy;
		burner_cmd_pkg::mode_t mode;
		logic [burner_cmd_pkg::REFRESH_W-1:0] timer;
		logic word_order;
		logic [15:0] held_word;
		logic [15:0] rdata;
		logic rvalid;
		logic fire_inhibit;
		logic drive_high;
		logic drive_low;
		logic remote_reset;
		logic remote_active;
	} state_t;

	state_t st_r;
	state_t st_nxt;
	logic [31:0] term_sync;

	// ----------------------------------------
	// Terminal pin synchronisation
	// ----------------------------------------
	bit_sync #(
		.WIDTH(burner_cmd_pkg::TERM_WIDTH)
	) u_term_sync (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_async(i_terminals),
		.o_sync(term_sync)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [7:0] low_byte;
		logic cmd_hit;
		logic cmd_valid;
		logic [15:0] first_word;
		logic [15:0] second_word;
		logic [15:0] status_word;
		low_byte = i_reg_wdata[7:0];
		cmd_hit = i_reg_wr && (i_reg_addr == burner_cmd_pkg::CMD_WORD_OFS);
		first_word = '0;
		second_word = '0;
		status_word = '0;
		st_nxt = st_r;
		st_nxt.remote_reset = 1'b0;

		// Only one low-byte bit among 0..4; bits 5-7 must be clear, bits 8-14 are not looked at.
		cmd_valid = $onehot(low_byte) && ((low_byte & burner_cmd_pkg::CMD_MUST_ZERO_MASK) == 8'h00);

		// Refresh timer runs only while a mode other than MODE_AUTO is held, MODE_OFF included.
		if (st_r.mode != burner_cmd_pkg::MODE_AUTO) begin
			if (st_r.timer >= REFRESH_CYCLES - burner_cmd_pkg::REFRESH_W'(1)) begin
				st_nxt.mode = burner_cmd_pkg::MODE_AUTO;
				st_nxt.timer = '0;
			end else begin
				st_nxt.timer = st_r.timer + burner_cmd_pkg::REFRESH_W'(1);
			end
		end

		// A valid write overrides a lapse in the same cycle, so a refresh is never lost.
		if (cmd_hit && cmd_valid) begin
			st_nxt.mode = st_r.mode;
			st_nxt.cmd_word = i_reg_wdata;
			st_nxt.ctl_copy = i_reg_wdata[burner_cmd_pkg::CMD_COPY_BIT];
			st_nxt.timer = '0;
			if (low_byte[burner_cmd_pkg::CMD_AUTO_BIT]) begin
				st_nxt.mode = burner_cmd_pkg::MODE_AUTO;
			end
			if (low_byte[burner_cmd_pkg::CMD_OFF_BIT]) begin
				st_nxt.mode = burner_cmd_pkg::MODE_OFF;
			end
			if (low_byte[burner_cmd_pkg::CMD_HIGH_BIT]) begin
				st_nxt.mode = burner_cmd_pkg::MODE_HIGH;
			end
			if (low_byte[burner_cmd_pkg::CMD_LOW_BIT]) begin
				st_nxt.mode = burner_cmd_pkg::MODE_LOW;
			end
			if (low_byte[burner_cmd_pkg::CMD_RESET_BIT]) begin
				st_nxt.remote_reset = 1'b1;
			end
		end

		if (i_reg_wr && (i_reg_addr == burner_cmd_pkg::WORD_ORDER_OFS)) begin
			st_nxt.word_order = i_reg_wdata[0];
		end

		// Outputs follow the mode being entered, so they change with the mode flip-flop.
		case (st_nxt.mode)
			burner_cmd_pkg::MODE_AUTO: begin
				st_nxt.fire_inhibit = 1'b0;
				st_nxt.drive_high = 1'b0;
				st_nxt.drive_low = 1'b0;
			end
			burner_cmd_pkg::MODE_OFF: begin
				st_nxt.fire_inhibit = 1'b1;
				st_nxt.drive_high = 1'b0;
				st_nxt.drive_low = 1'b0;
			end
			burner_cmd_pkg::MODE_HIGH: begin
				st_nxt.fire_inhibit = 1'b0;
				st_nxt.drive_high = i_run_phase;
				st_nxt.drive_low = 1'b0;
			end
			burner_cmd_pkg::MODE_LOW: begin
				st_nxt.fire_inhibit = 1'b0;
				st_nxt.drive_high = 1'b0;
				st_nxt.drive_low = i_run_phase;
			end
			default: begin
				st_nxt.fire_inhibit = 1'b0;
				st_nxt.drive_high = 1'b0;
				st_nxt.drive_low = 1'b0;
			end
		endcase
		st_nxt.remote_active = (st_nxt.mode != burner_cmd_pkg::MODE_AUTO);

		// Terminal bit n maps straight to status bit n, bit 0 least significant.
		if (st_r.word_order == burner_cmd_pkg::WORD_ORDER_LS_FIRST) begin
			first_word = term_sync[15:0];
			second_word = term_sync[31:16];
		end else begin
			first_word = term_sync[31:16];
			second_word = term_sync[15:0];
		end

		status_word[burner_cmd_pkg::CMD_COPY_BIT] = st_r.ctl_copy;
		status_word[burner_cmd_pkg::CMD_AUTO_BIT] = (st_r.mode == burner_cmd_pkg::MODE_AUTO);
		status_word[burner_cmd_pkg::CMD_OFF_BIT] = (st_r.mode == burner_cmd_pkg::MODE_OFF);
		status_word[burner_cmd_pkg::CMD_HIGH_BIT] = (st_r.mode == burner_cmd_pkg::MODE_HIGH);
		status_word[burner_cmd_pkg::CMD_LOW_BIT] = (st_r.mode == burner_cmd_pkg::MODE_LOW);

		// ----------------------------------------
		// Read decode
		// ----------------------------------------
		// The second half is taken from the snapshot made with the first, so both halves agree.
		st_nxt.rvalid = i_reg_rd;
		st_nxt.rdata = '0;
		if (i_reg_rd) begin
			case (i_reg_addr)
				burner_cmd_pkg::TERM_WORD_A_OFS: begin
					st_nxt.rdata = first_word;
					st_nxt.held_word = second_word;
				end
				burner_cmd_pkg::TERM_WORD_B_OFS: begin
					st_nxt.rdata = st_r.held_word;
				end
				burner_cmd_pkg::CMD_WORD_OFS: begin
					st_nxt.rdata = st_r.cmd_word;
				end
				burner_cmd_pkg::CTL_STATUS_OFS: begin
					st_nxt.rdata = status_word;
				end
				burner_cmd_pkg::WORD_ORDER_OFS: begin
					st_nxt.rdata = {15'h0000, st_r.word_order};
				end
				default: begin
					st_nxt.rdata = '0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_r <= '0;
			st_r.cmd_word <= burner_cmd_pkg::CMD_WORD_RESET;
			st_r.mode <= burner_cmd_pkg::MODE_AUTO;
			st_r.word_order <= burner_cmd_pkg::WORD_ORDER_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_reg_rdata = st_r.rdata;
	assign o_reg_rvalid = st_r.rvalid;
	assign o_fire_inhibit = st_r.fire_inhibit;
	assign o_drive_high_fire = st_r.drive_high;
	assign o_drive_low_fire = st_r.drive_low;
	assign o_remote_reset = st_r.remote_reset;
	assign o_remote_active = st_r.remote_active;

endmodule : burner_remote_command_regs

// *** tb/burner_cmd_properties.sv ***
// Assertions on the register port and the remote command outputs.
// Assumes it is bound to the top module; one clock domain.
`timescale 1ns/10ps
module burner_cmd_props (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Register port and control outputs
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [15:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	input wire logic o_reg_rvalid,
	input wire logic i_run_phase,
	input wire logic o_fire_inhibit,
	input wire logic o_drive_high_fire,
	input wire logic o_drive_low_fire,
	input wire logic o_remote_reset,
	input wire logic o_remote_active
);
	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	logic cw;
	logic bad;
	assign cw = i_reg_wr && (i_reg_addr == burner_cmd_pkg::CMD_WORD_OFS);
	assign bad = cw && !(i_reg_wdata[7:0] inside {8'h01, 8'h02, 8'h04, 8'h08, 8'h10});
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	read_answer_a: assert property (i_reg_rd |=> o_reg_rvalid) else $error("read not answered");
	no_answer_a: assert property (!i_reg_rd |=> !o_reg_rvalid) else $error("answer without read");
	high_fire_a: assert property (cw && i_reg_wdata[7:0] == 8'h04 && i_run_phase |=> o_drive_high_fire
		&& o_remote_active) else $error("high fire not driven");
	low_fire_a: assert property (cw && i_reg_wdata[7:0] == 8'h08 && i_run_phase |=> o_drive_low_fire
		&& !o_drive_high_fire) else $error("low fire not driven");
	stay_off_a: assert property (cw && i_reg_wdata[7:0] == 8'h02 |=> o_fire_inhibit
		&& !o_drive_high_fire && !o_drive_low_fire) else $error("off not held");
	auto_mode_a: assert property (cw && i_reg_wdata[7:0] == 8'h01 |=>
		!o_remote_active && !o_fire_inhibit) else $error("auto not restored");
	reset_pulse_a: assert property (cw && i_reg_wdata[7:0] == 8'h10 |=> o_remote_reset)
		else $error("remote reset missing");
	reset_cause_a: assert property (o_remote_reset |-> $past(cw && i_reg_wdata[7:0] == 8'h10))
		else $error("remote reset without command");
	reset_keeps_a: assert property (cw && i_reg_wdata[7:0] == 8'h10 |=>
		o_remote_active == $past(o_remote_active)) else $error("remote reset changed mode");
	run_gate_a: assert property (!i_run_phase |=> !o_drive_high_fire && !o_drive_low_fire)
		else $error("firing outside run");
	bad_cmd_a: assert property (bad |=> !o_remote_reset
		&& !$rose(o_remote_active) && !$rose(o_fire_inhibit)) else $error("invalid command acted on");
	cover property (cw && i_reg_wdata[7:0] == 8'h04 && i_run_phase);
	cover property (o_remote_reset);
	cover property (bad);
	cover property ($fell(o_remote_active));
endmodule : burner_cmd_props
bind burner_remote_command_regs burner_cmd_props u_props (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
	.i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
	.o_reg_rvalid(o_reg_rvalid), .i_run_phase(i_run_phase), .o_fire_inhibit(o_fire_inhibit),
	.o_drive_high_fire(o_drive_high_fire), .o_drive_low_fire(o_drive_low_fire),
	.o_remote_reset(o_remote_reset), .o_remote_active(o_remote_active));

// *** tb/burner_host.sv ***
// Host model: issues single-cycle register writes and reads.
// Assumes the bench calls its tasks; released lines show inverted values.
`timescale 1ns/10ps
module burner_host (
	// Clock
	input wire logic i_clk,
	// Register port requests
	output logic o_wr,
	output logic o_rd,
	output logic [15:0] o_addr,
	output logic [15:0] o_wdata
);
	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	initial begin
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = 16'hffff;
		o_wdata = 16'hffff;
	end
	// Callers send faulty command words only where a refusal is wanted.
	task wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge i_clk);
		o_wr <= 1'b1;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask : wr
	task rd(input logic [15:0] a);
		@(posedge i_clk);
		o_rd <= 1'b1;
		o_addr <= a;
		@(posedge i_clk);
		o_rd <= 1'b0;
		o_addr <= ~a;
	endtask : rd
	// The gap is scaled down with the refresh limit of the simulated design.
	task refresh(input logic [15:0] d, input int n, input int gap);
		repeat (n) begin
			wr(burner_cmd_pkg::CMD_WORD_OFS, d);
			repeat (gap) @(posedge i_clk);
		end
	endtask : refresh
endmodule : burner_host

// *** tb/burner_remote_command_regs_tb_top.sv ***
// Self-checking bench: host model drives, read answers are checked from a queue.
// Assumes a shortened refresh limit of REF cycles.
`timescale 1ns/10ps
module burner_remote_command_regs_tb_top;
	localparam int REF = 100;
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic run = 1'b0;
	logic wr, rd, rvalid, inh, hi, lo, rrst, act;
	logic [15:0] addr, wdata, rdata, e;
	logic [31:0] term = 32'h0000_0000;
	logic [15:0] expq[$];
	int err_count = 0, comparisons = 0, cyc = 0, seed = 75;
	int bits[7] = '{burner_cmd_pkg::TERM_RUN_TEST_BIT, burner_cmd_pkg::TERM_FAN_BIT,
		burner_cmd_pkg::TERM_ALARM_BIT, burner_cmd_pkg::TERM_MODULATE_BIT, burner_cmd_pkg::TERM_RESET_BIT,
		burner_cmd_pkg::TERM_SAFETY_RELAY_BIT, burner_cmd_pkg::TERM_FLAME_INTERLOCK_BIT};
	always #2 i_clk = ~i_clk;
	burner_host host (.i_clk(i_clk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
	burner_remote_command_regs #(.REFRESH_CYCLES(burner_cmd_pkg::REFRESH_W'(REF))) DUT (.i_clk(i_clk),
		.i_sys_rst(i_sys_rst), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_terminals(term), .i_run_phase(run),
		.o_fire_inhibit(inh), .o_drive_high_fire(hi), .o_drive_low_fire(lo), .o_remote_reset(rrst),
		.o_remote_active(act));
	// ----------------------------------------
	// Stimulus helpers and checking
	// ----------------------------------------
	task final_report;
		if (expq.size() != 0) begin
			err_count++;
			$display("[FAIL] pending reads expected 0 seen %0d", expq.size());
		end
		if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : final_report
	task chk(input logic [15:0] a, input logic [15:0] x);
		host.rd(a);
		expq.push_back(x);
	endtask : chk
	// Mode levels are looked at one step after the edge, once the flip-flops have settled.
	task lvl(input logic x);
		#1;
		comparisons++;
		if (act !== x || inh !== x) begin
			err_count++;
			$display("[FAIL] act/inh expected %b seen %b/%b", x, act, inh);
		end
	endtask : lvl
	task cmd(input logic [15:0] w, input logic [15:0] s);
		host.wr(burner_cmd_pkg::CMD_WORD_OFS, w);
		chk(burner_cmd_pkg::CTL_STATUS_OFS, s);
	endtask : cmd
	// Pins pass a two-flop synchroniser, so the word is read a few cycles later.
	task term_chk(input logic [31:0] t, input logic ord);
		@(posedge i_clk);
		term <= t;
		repeat (4) @(posedge i_clk);
		chk(burner_cmd_pkg::TERM_WORD_A_OFS, ord ? t[15:0] : t[31:16]);
		chk(burner_cmd_pkg::TERM_WORD_B_OFS, ord ? t[31:16] : t[15:0]);
	endtask : term_chk
	always @(posedge i_clk) begin
		run <= 1'($random(seed));
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			final_report();
		end
	end
	always @(negedge i_clk) begin
		if (rvalid === 1'b1) begin
			comparisons++;
			if (expq.size() == 0) begin
				err_count++;
				$display("[FAIL] rdata expected none seen %h", rdata);
			end else begin
				e = expq.pop_front();
				if (rdata !== e) begin
					err_count++;
					$display("[FAIL] rdata expected %h seen %h", e, rdata);
				end
			end
		end
	end
	initial begin
		repeat (8) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		chk(burner_cmd_pkg::CMD_WORD_OFS, burner_cmd_pkg::CMD_WORD_RESET);
		chk(burner_cmd_pkg::CTL_STATUS_OFS, 16'h0001);
		chk(burner_cmd_pkg::WORD_ORDER_OFS, 16'h0000);
		chk(16'h0070, 16'h0000);
		cmd(16'h8004, 16'h8004);
		cmd(16'h7f08, 16'h0008);
		cmd(16'h0006, 16'h0008);
		cmd(16'h0020, 16'h0008);
		cmd(16'h0000, 16'h0008);
		cmd(16'h8010, 16'h8008);
		cmd(16'h0002, 16'h0002);
		cmd(16'h0001, 16'h0001);
		host.refresh(16'h0002, 3, REF - 30);
		chk(burner_cmd_pkg::CTL_STATUS_OFS, 16'h0002);
		lvl(1'b1);
		repeat (40) @(posedge i_clk);
		chk(burner_cmd_pkg::CTL_STATUS_OFS, 16'h0001);
		lvl(1'b0);
		for (int o = 0; o < 2; o++) begin
			host.wr(burner_cmd_pkg::WORD_ORDER_OFS, 16'(o));
			chk(burner_cmd_pkg::WORD_ORDER_OFS, 16'(o));
			foreach (bits[i]) term_chk(32'h0000_0001 << bits[i], o[0]);
			term_chk(32'($random(seed)), o[0]);
		end
		repeat (4) @(posedge i_clk);
		final_report();
	end
endmodule : burner_remote_command_regs_tb_top
